// >>> bench/pmw_ctrl_tb.sv
// Register-level testbench of the pull-up, mux and output-write block
`include "pmw_params.svh"
`default_nettype none
module pmw_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmw_pkg::*;
  // =========================================
  // Signals and design under test
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
  pmw_addr_t paddr;
  pmw_word_t pwdata;
  logic [31:0] prdata, pullup_on, periph_b_sel, line_out;
  int fails, n_tests;
  pmw_word_t q;
  logic e;
  pmw_ctrl u_pmw_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pullup_on(pullup_on), .periph_b_sel(periph_b_sel),
    .line_out(line_out));
  // 100 ns system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // =========================================
  // Shared tasks
  task automatic final_report;
    $display("checks %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare one word, count and report
  task automatic chk(input string nm, input pmw_word_t exp, input pmw_word_t got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic wr, input pmw_addr_t a, input pmw_word_t d,
                     output pmw_word_t rq, output logic re);
    int i;
    logic ok;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    ok = (pready === 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      fails++;
      $display("[ERR] pready expected 1 seen timeout");
      final_report();
    end else begin
      // A write lands at this edge: one more edge lets the ports settle before compares
      @(posedge clk_sys);
    end
  endtask
  task automatic wr(input pmw_addr_t a, input pmw_word_t d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input string nm, input pmw_addr_t a, input pmw_word_t exp);
    apb(1'b0, a, 32'h00000000, q, e);
    chk(nm, exp, q);
  endtask
  // =========================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    fails = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd("pullup_status", `PMW_OFF_PULLUP_STATUS, 32'h00000000);
    chk("pslverr", 32'h00000000, {31'h0, e});
    chk("pullup_on", 32'hffffffff, pullup_on);
    chk("periph_b_sel", 32'h00000000, periph_b_sel);
    chk("line_out", 32'h00000000, line_out);
    rd("periph_assign_status", `PMW_OFF_PERIPH_ASSIGN_STATUS, 32'h00000000);
    rd("out_write_status", `PMW_OFF_OUT_WRITE_STATUS, 32'h00000000);
    rd("output_data_status", `PMW_OFF_OUTPUT_DATA_STATUS, 32'h00000000);
    $display("test reset done");
    wr(`PMW_OFF_PULLUP_DISABLE, 32'h000000f0);
    chk("pullup_on", 32'hffffff0f, pullup_on);
    wr(`PMW_OFF_PULLUP_DISABLE, 32'h00000000);
    rd("pullup_status", `PMW_OFF_PULLUP_STATUS, 32'h000000f0);
    wr(`PMW_OFF_PULLUP_ENABLE, 32'h00000030);
    wr(`PMW_OFF_PULLUP_ENABLE, 32'h00000000);
    wr(`PMW_OFF_PULLUP_STATUS, 32'hffffffff);
    rd("pullup_status", `PMW_OFF_PULLUP_STATUS, 32'h000000c0);
    chk("pullup_on", 32'hffffff3f, pullup_on);
    $display("test pull-up done");
    wr(`PMW_OFF_PERIPH_B_SELECT, 32'ha5a50001);
    chk("periph_b_sel", 32'ha5a50001, periph_b_sel);
    wr(`PMW_OFF_PERIPH_A_SELECT, 32'h00000001);
    wr(`PMW_OFF_PERIPH_B_SELECT, 32'h00000000);
    rd("periph_assign_status", `PMW_OFF_PERIPH_ASSIGN_STATUS, 32'ha5a50000);
    chk("periph_b_sel", 32'ha5a50000, periph_b_sel);
    $display("test mux done");
    wr(`PMW_OFF_OUTPUT_DATA_STATUS, 32'hffffffff);
    chk("line_out", 32'h00000000, line_out);
    wr(`PMW_OFF_OUT_WRITE_ENABLE, 32'h0000ffff);
    rd("out_write_status", `PMW_OFF_OUT_WRITE_STATUS, 32'h0000ffff);
    wr(`PMW_OFF_OUTPUT_DATA_STATUS, 32'hffffffff);
    chk("line_out", 32'h0000ffff, line_out);
    rd("output_data_status", `PMW_OFF_OUTPUT_DATA_STATUS, 32'h0000ffff);
    wr(`PMW_OFF_OUT_WRITE_DISABLE, 32'h000000ff);
    rd("out_write_status", `PMW_OFF_OUT_WRITE_STATUS, 32'h0000ff00);
    wr(`PMW_OFF_OUTPUT_DATA_STATUS, 32'h00000000);
    chk("line_out", 32'h000000ff, line_out);
    $display("test output write done");
    apb(1'b1, 8'h40, 32'hffffffff, q, e);
    chk("pslverr", 32'h00000001, {31'h0, e});
    chk("line_out", 32'h000000ff, line_out);
    rd("unmapped", 8'h40, 32'h00000000);
    chk("pslverr", 32'h00000001, {31'h0, e});
    rd("pullup_disable", `PMW_OFF_PULLUP_DISABLE, 32'h00000000);
    chk("pslverr", 32'h00000000, {31'h0, e});
    wr(`PMW_OFF_PERIPH_ASSIGN_STATUS, 32'hffffffff);
    wr(`PMW_OFF_OUT_WRITE_STATUS, 32'hffffffff);
    rd("periph_assign_status", `PMW_OFF_PERIPH_ASSIGN_STATUS, 32'ha5a50000);
    rd("out_write_status", `PMW_OFF_OUT_WRITE_STATUS, 32'h0000ff00);
    rd("pullup_status", `PMW_OFF_PULLUP_STATUS, 32'h000000c0);
    $display("test access done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    chk("pullup_on", 32'hffffffff, pullup_on);
    chk("periph_b_sel", 32'h00000000, periph_b_sel);
    chk("line_out", 32'h00000000, line_out);
    rd("pullup_status", `PMW_OFF_PULLUP_STATUS, 32'h00000000);
    rd("out_write_status", `PMW_OFF_OUT_WRITE_STATUS, 32'h00000000);
    $display("test mid-run reset done");
    final_report();
  end
endmodule // pmw_ctrl_tb
`default_nettype wire

// >>> hdl/pmw_ctrl.sv
// APB slave holding per-line pull-up, peripheral mux and output write gating
// Function
// [RULE1] A one written to pullup_disable switches that line's pull-up off; a zero leaves it.
// [RULE2] A one written to pullup_enable switches that line's pull-up on; a zero does nothing.
// [RULE3] pullup_status reads zero for an active pull-up and one for a disabled one.
// [RULE4] A one written to periph_a_select gives the line to peripheral A; a zero does nothing.
// [RULE5] A one written to periph_b_select gives the line to peripheral B; a zero does nothing.
// [RULE6] periph_assign_status reads zero for peripheral A and one for peripheral B per line.
// [RULE7] A one written to out_write_enable lets later output data writes update that line.
// [RULE8] A one written to out_write_disable stops output data writes from updating that line.
// [RULE9] out_write_status reads one where an output data write changes the line, else zero.
// [RULE10] Each output data bit holds the level driven on its line, one high and zero low.
// [RULE11] Bit n of every register belongs to line n, each line stored on its own.
//
// The address map and the APB register port are this design's own decisions.
`include "pmw_params.svh"
`default_nettype none
module pmw_ctrl #(
  parameter int LINES = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pmw_pkg::pmw_addr_t paddr,
  input wire pmw_pkg::pmw_word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [LINES-1:0] pullup_on,
  output logic [LINES-1:0] periph_b_sel,
  output logic [LINES-1:0] line_out
);
  import pmw_pkg::*;

  // ==========================================================
  // Register state
  logic [LINES-1:0] pullup_off;
  logic [LINES-1:0] periph_b;
  logic [LINES-1:0] out_wr_en;
  logic [LINES-1:0] out_data;
  logic [LINES-1:0] next_pullup_off;
  logic [LINES-1:0] next_periph_b;
  logic [LINES-1:0] next_out_wr_en;
  logic [LINES-1:0] next_out_data;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_acc;
  logic rd_acc;
  logic known;
  logic [LINES-1:0] wdata;

  // Returns one when the address names a mapped register
  function automatic logic pmw_mapped(input pmw_addr_t a);
    case (a)
      `PMW_OFF_PULLUP_DISABLE, `PMW_OFF_PULLUP_ENABLE, `PMW_OFF_PULLUP_STATUS,
      `PMW_OFF_PERIPH_A_SELECT, `PMW_OFF_PERIPH_B_SELECT,
      `PMW_OFF_PERIPH_ASSIGN_STATUS, `PMW_OFF_OUT_WRITE_ENABLE,
      `PMW_OFF_OUT_WRITE_DISABLE, `PMW_OFF_OUT_WRITE_STATUS,
      `PMW_OFF_OUTPUT_DATA_STATUS: pmw_mapped = 1'b1;
      default: pmw_mapped = 1'b0;
    endcase
  endfunction

  // Pads a line vector into a bus word
  function automatic pmw_word_t pmw_word(input logic [LINES-1:0] v);
    pmw_word_t w;
    w = `PMW_ZERO_WORD;
    w[LINES-1:0] = v;
    pmw_word = w;
  endfunction

  // ==========================================================
  // Access decode: pready comes in the access phase with no wait state; a write commits
  // only at the edge that completes the transfer, a read is looked up in the setup cycle
  assign known = pmw_mapped(paddr);
  assign wdata = pwdata[LINES-1:0];
  assign wr_acc = psel && penable && pready && pwrite && known;
  assign rd_acc = psel && !penable && !pwrite;

  // Next state of configuration bits, set and clear per line
  always_comb begin
    next_pullup_off = pullup_off;
    next_periph_b = periph_b;
    next_out_wr_en = out_wr_en;
    next_out_data = out_data;
    if (wr_acc) begin
      unique case (paddr)
        `PMW_OFF_PULLUP_DISABLE: next_pullup_off = pullup_off | wdata; // [RULE1] [RULE11]
        `PMW_OFF_PULLUP_ENABLE: next_pullup_off = pullup_off & ~wdata; // [RULE2]
        `PMW_OFF_PERIPH_A_SELECT: next_periph_b = periph_b & ~wdata; // [RULE4]
        `PMW_OFF_PERIPH_B_SELECT: next_periph_b = periph_b | wdata; // [RULE5]
        `PMW_OFF_OUT_WRITE_ENABLE: next_out_wr_en = out_wr_en | wdata; // [RULE7]
        `PMW_OFF_OUT_WRITE_DISABLE: next_out_wr_en = out_wr_en & ~wdata; // [RULE8]
        // Only write-enabled lines take the new level
        `PMW_OFF_OUTPUT_DATA_STATUS: begin
          next_out_data = (out_data & ~out_wr_en) | (wdata & out_wr_en); // [RULE10]
        end
        default: next_out_data = out_data;
      endcase
    end
  end

  // Read mux and answer flags
  always_comb begin
    next_prdata = `PMW_ZERO_WORD;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_pslverr = !known;
    end
    if (rd_acc) begin
      case (paddr)
        `PMW_OFF_PULLUP_STATUS: next_prdata = pmw_word(pullup_off); // [RULE3]
        `PMW_OFF_PERIPH_ASSIGN_STATUS: next_prdata = pmw_word(periph_b); // [RULE6]
        `PMW_OFF_OUT_WRITE_STATUS: next_prdata = pmw_word(out_wr_en); // [RULE9]
        `PMW_OFF_OUTPUT_DATA_STATUS: next_prdata = pmw_word(out_data); // [RULE10]
        default: next_prdata = `PMW_ZERO_WORD;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pullup_off <= LINES'(`PMW_RST_PULLUP_OFF);
      periph_b <= LINES'(`PMW_RST_PERIPH_B);
      out_wr_en <= LINES'(`PMW_RST_OUT_WRITE);
      out_data <= LINES'(`PMW_RST_OUTPUT_DATA);
      prdata <= `PMW_ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pullup_on <= ~LINES'(`PMW_RST_PULLUP_OFF);
      periph_b_sel <= LINES'(`PMW_RST_PERIPH_B);
      line_out <= LINES'(`PMW_RST_OUTPUT_DATA);
    end else begin
      pullup_off <= next_pullup_off;
      periph_b <= next_periph_b;
      out_wr_en <= next_out_wr_en;
      out_data <= next_out_data;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      pullup_on <= ~next_pullup_off; // [RULE1] [RULE2]
      periph_b_sel <= next_periph_b; // [RULE4] [RULE5]
      line_out <= next_out_data; // [RULE10]
    end
  end

  // ==========================================================
  // Checks
  property p_pullup_off_set;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PULLUP_DISABLE) |=>
        ((pullup_off & $past(wdata)) == $past(wdata));
  endproperty
  a_pullup_off_set: assert property (p_pullup_off_set) else $error("pull-up not disabled"); // [RULE1]

  property p_pullup_on_set;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PULLUP_ENABLE) |=>
        ((pullup_on & $past(wdata)) == $past(wdata));
  endproperty
  a_pullup_on_set: assert property (p_pullup_on_set) else $error("pull-up not enabled"); // [RULE2]

  property p_pullup_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (rd_acc && paddr == `PMW_OFF_PULLUP_STATUS) |=> (prdata[LINES-1:0] == ~pullup_on);
  endproperty
  a_pullup_read: assert property (p_pullup_read) else $error("pull-up status wrong sense"); // [RULE3]

  property p_sel_a;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PERIPH_A_SELECT) |=>
        ((periph_b_sel & $past(wdata)) == '0);
  endproperty
  a_sel_a: assert property (p_sel_a) else $error("line not given to A"); // [RULE4]

  property p_sel_b;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PERIPH_B_SELECT) |=>
        ((periph_b_sel | ~$past(wdata)) == '1);
  endproperty
  a_sel_b: assert property (p_sel_b) else $error("line not given to B"); // [RULE5]

  property p_assign_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (rd_acc && paddr == `PMW_OFF_PERIPH_ASSIGN_STATUS) |=> (prdata[LINES-1:0] == periph_b_sel);
  endproperty
  a_assign_read: assert property (p_assign_read) else $error("assign status wrong"); // [RULE6]

  property p_owr_enable;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_OUT_WRITE_ENABLE) |=>
        ((out_wr_en & $past(wdata)) == $past(wdata));
  endproperty
  a_owr_enable: assert property (p_owr_enable) else $error("write enable not set"); // [RULE7]

  property p_owr_gate;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_OUTPUT_DATA_STATUS) |=>
        ((line_out & ~$past(out_wr_en)) == ($past(line_out) & ~$past(out_wr_en)));
  endproperty
  a_owr_gate: assert property (p_owr_gate) else $error("gated line changed"); // [RULE8]

  property p_owr_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (rd_acc && paddr == `PMW_OFF_OUT_WRITE_STATUS) |=> (prdata[LINES-1:0] == out_wr_en);
  endproperty
  a_owr_read: assert property (p_owr_read) else $error("write status wrong"); // [RULE9]

  property p_data_write;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_OUTPUT_DATA_STATUS) |=>
        ((line_out & $past(out_wr_en)) == ($past(wdata) & $past(out_wr_en)));
  endproperty
  a_data_write: assert property (p_data_write) else $error("enabled line not updated"); // [RULE10] [RULE11]

  property p_ready_answer;
    @(posedge clk_sys) disable iff (!rst_b)
      (psel && !penable) |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready in access phase");

  property p_pullup_off_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PULLUP_DISABLE) |=>
        ((pullup_off & ~$past(wdata)) == ($past(pullup_off) & ~$past(wdata)));
  endproperty
  a_pullup_off_keep: assert property (p_pullup_off_keep) else $error("pull-up moved by a zero"); // [RULE1]

  property p_pullup_on_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PULLUP_ENABLE) |=>
        ((pullup_on & ~$past(wdata)) == ($past(pullup_on) & ~$past(wdata)));
  endproperty
  a_pullup_on_keep: assert property (p_pullup_on_keep) else $error("pull-up moved by a zero"); // [RULE2]

  property p_sel_a_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PERIPH_A_SELECT) |=>
        ((periph_b_sel & ~$past(wdata)) == ($past(periph_b_sel) & ~$past(wdata)));
  endproperty
  a_sel_a_keep: assert property (p_sel_a_keep) else $error("mux moved by a zero"); // [RULE4]

  property p_sel_b_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_PERIPH_B_SELECT) |=>
        ((periph_b_sel & ~$past(wdata)) == ($past(periph_b_sel) & ~$past(wdata)));
  endproperty
  a_sel_b_keep: assert property (p_sel_b_keep) else $error("mux moved by a zero"); // [RULE5]

  property p_owr_enable_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_OUT_WRITE_ENABLE) |=>
        ((out_wr_en & ~$past(wdata)) == ($past(out_wr_en) & ~$past(wdata)));
  endproperty
  a_owr_enable_keep: assert property (p_owr_enable_keep) else $error("gate moved by a zero"); // [RULE7]

  property p_owr_disable;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_OUT_WRITE_DISABLE) |=>
        ((out_wr_en & $past(wdata)) == '0);
  endproperty
  a_owr_disable: assert property (p_owr_disable) else $error("write enable not cleared"); // [RULE8]

  property p_owr_disable_keep;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && paddr == `PMW_OFF_OUT_WRITE_DISABLE) |=>
        ((out_wr_en & ~$past(wdata)) == ($past(out_wr_en) & ~$past(wdata)));
  endproperty
  a_owr_disable_keep: assert property (p_owr_disable_keep) else $error("gate moved by a zero"); // [RULE8]

  property p_odsr_read;
    @(posedge clk_sys) disable iff (!rst_b)
      (rd_acc && paddr == `PMW_OFF_OUTPUT_DATA_STATUS) |=>
        (prdata[LINES-1:0] == line_out);
  endproperty
  a_odsr_read: assert property (p_odsr_read) else $error("output data read wrong"); // [RULE10]

  property p_data_held;
    @(posedge clk_sys) disable iff (!rst_b)
      !(wr_acc && paddr == `PMW_OFF_OUTPUT_DATA_STATUS) |=>
        $stable(line_out);
  endproperty
  a_data_held: assert property (p_data_held) else $error("line level moved without write"); // [RULE10]

  property p_pullup_held;
    @(posedge clk_sys) disable iff (!rst_b)
      !(wr_acc && (paddr == `PMW_OFF_PULLUP_DISABLE || paddr == `PMW_OFF_PULLUP_ENABLE)) |=>
        $stable(pullup_on);
  endproperty
  a_pullup_held: assert property (p_pullup_held) else $error("pull-up moved without write"); // [RULE11]

  property p_status_write_ignored;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr_acc && (paddr == `PMW_OFF_PULLUP_STATUS || paddr == `PMW_OFF_PERIPH_ASSIGN_STATUS ||
        paddr == `PMW_OFF_OUT_WRITE_STATUS)) |=>
        ($stable(pullup_on) && $stable(periph_b_sel) && $stable(out_wr_en) && $stable(line_out));
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) else $error("status took a write"); // [RULE3] [RULE6] [RULE9]

  property p_unmapped_error;
    @(posedge clk_sys) disable iff (!rst_b)
      (psel && !penable && !known) |=> (pready && pslverr && (prdata == `PMW_ZERO_WORD));
  endproperty
  a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped access not refused");

  property p_ready_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
      pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  property p_err_with_ready;
    @(posedge clk_sys) disable iff (!rst_b)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error outside access phase");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (!rst_b)
      !pready |-> (prdata == `PMW_ZERO_WORD);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access phase");
endmodule // pmw_ctrl
`default_nettype wire

// >>> hdl/pmw_params.svh
// Register offsets, widths and reset values of the pull-up, mux and output-write block
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH
`define PMW_ADDR_W 8
`define PMW_OFF_PULLUP_DISABLE 8'h00
`define PMW_OFF_PULLUP_ENABLE 8'h04
`define PMW_OFF_PULLUP_STATUS 8'h08
`define PMW_OFF_PERIPH_A_SELECT 8'h0c
`define PMW_OFF_PERIPH_B_SELECT 8'h10
`define PMW_OFF_PERIPH_ASSIGN_STATUS 8'h14
`define PMW_OFF_OUT_WRITE_ENABLE 8'h18
`define PMW_OFF_OUT_WRITE_DISABLE 8'h1c
`define PMW_OFF_OUT_WRITE_STATUS 8'h20
`define PMW_OFF_OUTPUT_DATA_STATUS 8'h24
`define PMW_RST_PULLUP_OFF 32'h00000000
`define PMW_RST_PERIPH_B 32'h00000000
`define PMW_RST_OUT_WRITE 32'h00000000
`define PMW_RST_OUTPUT_DATA 32'h00000000
`define PMW_ZERO_WORD 32'h00000000
`endif

// >>> hdl/pmw_pkg.sv
// Types shared by the pull-up, mux and output-write block
`default_nettype none
package pmw_pkg;
  typedef logic [31:0] pmw_word_t;
  typedef logic [7:0] pmw_addr_t;
endpackage
`default_nettype wire
